/* tss_top.v */
// timed sequencer plus step sequencer with synchronised inputs
// assumes trigger/clear come from pins or other blocks on any timing
`include "tss_map.vh"
module tss_top #(
   parameter integer TICK_CYC = `TSS_CLK_HZ
) (
   // clock and reset
   input  wire                  clk,
   input  wire                  resetn,
   // timed sequencer inputs
   input  wire                  timed_sequencer_trigger_input,
   input  wire                  timed_sequencer_clear,
   input  wire [2:0]            timed_sequencer_last_sel,
   input  wire [1:0]            timed_sequencer_unit,
   input  wire [7*`TSS_DLY_W-1:0] timed_sequencer_delay,
   // timed sequencer outputs
   output reg  [7:0]            timed_sequencer_q,
   output wire                  timed_sequencer_done,
   // step sequencer
   input  wire                  step_sequencer_trigger_input,
   input  wire                  step_sequencer_clear,
   input  wire [2:0]            step_sequencer_last_sel,
   output wire [7:0]            step_sequencer_q
);
   // three-stage synchronisers; a level counts once stages 2 and 3 agree
   reg  [2:0] s_ttrg_r, s_tclr_r, s_strg_r, s_sclr_r;
   reg        ttrg_r, tclr_r, strg_r, sclr_r, strg_d_r;

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s_ttrg_r <= 3'h0;
         s_tclr_r <= 3'h0;
         s_strg_r <= 3'h0;
         s_sclr_r <= 3'h0;
         ttrg_r   <= 1'b0;
         tclr_r   <= 1'b0;
         strg_r   <= 1'b0;
         sclr_r   <= 1'b0;
         strg_d_r <= 1'b0;
      end else begin
         s_ttrg_r <= {s_ttrg_r[1:0], timed_sequencer_trigger_input};
         s_tclr_r <= {s_tclr_r[1:0], timed_sequencer_clear};
         s_strg_r <= {s_strg_r[1:0], step_sequencer_trigger_input};
         s_sclr_r <= {s_sclr_r[1:0], step_sequencer_clear};
         if (s_ttrg_r[1] == s_ttrg_r[2]) ttrg_r <= s_ttrg_r[2];
         if (s_tclr_r[1] == s_tclr_r[2]) tclr_r <= s_tclr_r[2];
         if (s_strg_r[1] == s_strg_r[2]) strg_r <= s_strg_r[2];
         if (s_sclr_r[1] == s_sclr_r[2]) sclr_r <= s_sclr_r[2];
         strg_d_r <= strg_r;
      end
   end

   wire strig_rise = strg_r & ~strg_d_r;

   // timed sequencer: tick counter gives one-unit ticks, elapsed counts them
   localparam [31:0] TICK_MAX = TICK_CYC - 1;
   reg  [31:0]           pre_r;
   reg  [11:0]           sub_r;
   reg  [`TSS_DLY_W-1:0] elapsed_r;
   reg                   run_r;
   reg                   done_r;
   reg  [11:0]           sub_max;
   wire                  sec_tick = (pre_r == TICK_MAX);

   always @* begin
      case (timed_sequencer_unit)
         `TSS_UNIT_MIN:  sub_max = 12'd59;
         `TSS_UNIT_HOUR: sub_max = 12'd3599;
         default:        sub_max = 12'h000;
      endcase
   end

   wire unit_tick = sec_tick && (sub_r >= sub_max);
   wire [2:0] last = (timed_sequencer_last_sel == 3'h0) ? 3'h1 : timed_sequencer_last_sel;
   reg  [7:0] reach;
   integer i;
   always @* begin
      reach = 8'h00;
      for (i = 1; i < 8; i = i + 1)
         reach[i] = (i <= last) &&
                    (elapsed_r >= timed_sequencer_delay[(i-1)*`TSS_DLY_W +: `TSS_DLY_W]);
   end

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pre_r     <= 32'h0;
         sub_r     <= 12'h000;
         elapsed_r <= {`TSS_DLY_W{1'b0}};
         run_r     <= 1'b0;
         done_r    <= 1'b0;
         timed_sequencer_q    <= 8'h01;
      end else if (tclr_r) begin
         pre_r     <= 32'h0;
         sub_r     <= 12'h000;
         elapsed_r <= {`TSS_DLY_W{1'b0}};
         run_r     <= 1'b0;
         done_r    <= 1'b0;
         timed_sequencer_q    <= 8'h01;
      end else if (!run_r) begin
         if (ttrg_r && !done_r) begin
            run_r <= 1'b1;
            pre_r <= 32'h0;
         end
         timed_sequencer_q[0] <= 1'b1;
      end else begin
         pre_r <= sec_tick ? 32'h0 : pre_r + 32'h1;
         if (sec_tick)
            sub_r <= unit_tick ? 12'h000 : sub_r + 12'h001;
         if (unit_tick)
            elapsed_r <= elapsed_r + {{(`TSS_DLY_W-1){1'b0}}, 1'b1};
         timed_sequencer_q <= timed_sequencer_q | reach | 8'h01;
         if (reach[last]) begin
            run_r  <= 1'b0;
            done_r <= 1'b1;
         end
      end
   end
   assign timed_sequencer_done = done_r;

   tss_step_seq u_step (
      .clk       (clk),
      .resetn    (resetn),
      .trig_rise (strig_rise),
      .clear     (sclr_r),
      .last_sel  (step_sequencer_last_sel),
      .q         (step_sequencer_q)
   );
endmodule // tss_top

/* tss_map.vh */
// constants for the timed and step sequencer pair
// assumes a 125 MHz block clock; delays counted in whole time-unit ticks
// Behaviour
// - The timed sequencer has eight outputs 0..7 driven by a trigger and a clear input.
// - Timed output 0 is always on, regardless of clear or trigger, and cannot be changed.
// - After a trigger, timed outputs 1..7 turn on one at a time in ascending order and only they obey clear; each turns on at its own delay instead.
// - Clear drives timed outputs 1..7 to zero.
// - The seven selectable timed outputs stay on together once reached.
// - Selecting an output in either sequencer also selects every lower-numbered output.
// - Each of timed outputs 1..7 has its own turn-on delay from the trigger, in seconds, minutes or hours.
// - With one-second spacing output k turns on at second k and sequencing stops once the last selected output is on.
// - A finished timed sequence restarts only after clear has been asserted.
// - The step sequencer has eight outputs 0..7 and turns outputs 1..7 on one after another by trigger.
// - Each step trigger pulse turns on exactly one further selected output in ascending order.
// - Once all selected step outputs are on, further pulses turn them off one by one, output 0 stays on, and it repeats.
// - Clear forces the step sequencer's sequenced outputs off.
// - Step output 0 is fixed on and outputs 1 and 2 are always sequenced; only outputs 2..7 are selectable as last.
`ifndef TSS_MAP_VH
`define TSS_MAP_VH
`define TSS_CLK_HZ        125000000
`define TSS_SEC_PER_MIN   60
`define TSS_SEC_PER_HOUR  3600
`define TSS_UNIT_SEC      2'h0
`define TSS_UNIT_MIN      2'h1
`define TSS_UNIT_HOUR     2'h2
`define TSS_NOUT          8
`define TSS_DLY_W         14
`define TSS_LAST_W        3
`endif

/* tss_step_seq.v */
// step sequencer: one output per trigger edge, then off one by one
// assumes trigger and clear already synchronised to clk
`include "tss_map.vh"
module tss_step_seq (
   // clock and reset
   input  wire       clk,
   input  wire       resetn,
   // control
   input  wire       trig_rise,
   input  wire       clear,
   input  wire [2:0] last_sel,
   // outputs
   output wire [7:0] q
);
   reg  [2:0] level_r;
   reg        down_r;
   reg  [2:0] top;

   always @* begin
      top = (last_sel < 3'h2) ? 3'h2 : last_sel;
   end

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         level_r <= 3'h0;
         down_r  <= 1'b0;
      end else if (clear) begin
         level_r <= 3'h0;
         down_r  <= 1'b0;
      end else if (trig_rise) begin
         if (!down_r) begin
            if (level_r >= top) begin
               down_r  <= 1'b1;
               level_r <= level_r - 3'h1;
            end else begin
               level_r <= level_r + 3'h1;
            end
         end else begin
            level_r <= level_r - 3'h1;
            if (level_r == 3'h1)
               down_r <= 1'b0;
         end
      end
   end

   genvar k;
   generate
      for (k = 1; k < 8; k = k + 1) begin : g_q
         assign q[k] = (level_r >= k);
      end
   endgenerate
   assign q[0] = 1'b1;
endmodule // tss_step_seq

/* tss_pulse_src.sv */
// upstream block giving trigger pulses
// assumes go lasts one clk
module tss_pulse_src (
   input  logic clk,
   input  logic go,
   input  logic hold,
   output logic trig
);
   timeunit 1ns;
   timeprecision 1ps;
   int n = 0;
   // 4 high then 4 low, long enough for the input sync
   always @(posedge clk) begin
      n <= go ? 8 : (n > 0 ? n - 1 : 0);
   end
   assign trig = hold | (n > 4);
endmodule // tss_pulse_src

/* tss_top_sva.sv */
// checker for the sequencer pair outputs
// assumes binding into tss_top
module tss_top_sva (
   input logic       clk,
   input logic       resetn,
   input logic       timed_sequencer_clear,
   input logic [2:0] timed_sequencer_last_sel,
   input logic [7:0] timed_sequencer_q,
   input logic       timed_sequencer_done,
   input logic       step_sequencer_clear,
   input logic [2:0] step_sequencer_last_sel,
   input logic [7:0] step_sequencer_q
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (!resetn);
   a_t0_on: assert property (timed_sequencer_q[0]) else $error("tq0");
   a_s0_on: assert property (step_sequencer_q[0]) else $error("sq0");
   a_t_order: assert property (((timed_sequencer_q + 8'h01) & timed_sequencer_q) == 8'h00) else $error("tq");
   a_s_order: assert property (((step_sequencer_q + 8'h01) & step_sequencer_q) == 8'h00) else $error("sq");
   a_t_clear: assert property (timed_sequencer_clear [*8] |-> timed_sequencer_q == 8'h01) else $error("tc");
   a_s_clear: assert property (step_sequencer_clear [*8] |-> step_sequencer_q == 8'h01) else $error("sc");
   a_s_one_step: assert property (step_sequencer_q != $past(step_sequencer_q) |-> step_sequencer_q == 8'h01 ||
      $countones(step_sequencer_q ^ $past(step_sequencer_q)) == 1) else $error("jump");
   a_t_done_at: assert property ($rose(timed_sequencer_done) |-> $countones(timed_sequencer_q) ==
      (timed_sequencer_last_sel == 3'h0 ? 2 : timed_sequencer_last_sel + 1)) else $error("done");
   // the sum is 4 bits wide so a top selection of 7 does not wrap
   a_s_top_sel: assert property ((step_sequencer_q >>
      (4'h1 + (step_sequencer_last_sel < 3'h2 ? 3'h2 : step_sequencer_last_sel))) == 8'h00) else $error("sel");
endmodule // tss_top_sva
bind tss_top tss_top_sva u_tss_top_sva (.clk, .resetn, .timed_sequencer_clear, .timed_sequencer_last_sel,
   .timed_sequencer_q, .timed_sequencer_done, .step_sequencer_clear, .step_sequencer_last_sel, .step_sequencer_q);

/* test_time_step_sequencer.sv */
// self-checking bench for tss_top
// assumes a 10-cycle second through TICK_CYC
`include "tss_map.vh"
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin failures++; \
   $display("mismatch %s %h %h", n, e, s); end end
module test_time_step_sequencer;
   timeunit 1ns;
   timeprecision 1ps;
   logic                    clk = 0, resetn = 0, tt = 0, tc = 0, sc = 0, go = 0, hold = 0;
   logic                    st, done;
   logic [2:0]              tl = 7, sl = 3;
   logic [1:0]              tu = 0;
   logic [7:0]              tq, sq;
   logic [7*`TSS_DLY_W-1:0] td = 0;
   logic [10:0]             rows [7] = '{11'h303, 11'h307, 11'h30F, 11'h307, 11'h303,
                                         11'h301, 11'h303};
   int                      failures = 0, checks = 0;
   tss_top #(.TICK_CYC(10)) u_tss_top (.clk, .resetn, .timed_sequencer_trigger_input(tt),
      .timed_sequencer_clear(tc), .timed_sequencer_last_sel(tl), .timed_sequencer_unit(tu), .timed_sequencer_delay(td), .timed_sequencer_q(tq),
      .timed_sequencer_done(done), .step_sequencer_trigger_input(st), .step_sequencer_clear(sc), .step_sequencer_last_sel(sl),
      .step_sequencer_q(sq));
   tss_pulse_src u_tss_pulse_src (.clk, .go, .hold, .trig(st));
   initial begin
      forever #4 clk = ~clk;
   end
   task automatic cyc(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic pulse;
      go = 1;
      cyc(1);
      go = 0;
      cyc(11);
   endtask
   task automatic finish_test;
      if (failures == 0 && checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      cyc(3000);
      failures++;
      finish_test();
   end
   initial begin
      for (int k = 0; k < 7; k++) td[k*14 +: 14] = 14'(k + 1);
      cyc(4);
      `CHK("tq", 8'h01, tq)
      resetn = 1;
      cyc(8);
      foreach (rows[i]) begin
         sl = rows[i][10:8];
         pulse();
         `CHK("sq", rows[i][7:0], sq)
      end
      hold = 1;
      cyc(20);
      hold = 0;
      cyc(8);
      `CHK("sq", 8'h07, sq)
      sc = 1;
      cyc(10);
      pulse();
      `CHK("sq", 8'h01, sq)
      sc = 0;
      sl = 0;
      cyc(8);
      pulse();
      pulse();
      pulse();
      `CHK("sq", 8'h03, sq)
      tt = 1;
      cyc(9);
      for (int k = 1; k < 8; k++) begin
         cyc(10);
         `CHK("tq", 8'((2 << k) - 1), tq)
      end
      `CHK("done", 1'b1, done)
      tc = 1;
      cyc(10);
      `CHK("tq", 8'h01, tq)
      tc = 0;
      tt = 0;
      tl = 1;
      cyc(8);
      tt = 1;
      cyc(40);
      `CHK("tq", 8'h03, tq)
      tc = 1;
      tt = 0;
      cyc(10);
      tc = 0;
      tu = `TSS_UNIT_MIN;
      cyc(8);
      tt = 1;
      cyc(300);
      `CHK("tq", 8'h01, tq)
      cyc(330);
      `CHK("tq", 8'h03, tq)
      finish_test();
   end
endmodule // test_time_step_sequencer
